// file: logic/spl_pkg.sv
package spl_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] REG_LINE_CFG  = 8'h00;
  localparam logic [7:0] REG_PORT_CFG  = 8'h04;
  localparam logic [7:0] REG_TIMEOUT   = 8'h08;
  localparam logic [7:0] REG_ACCESS    = 8'h0C;
  localparam logic [7:0] REG_TX_DATA   = 8'h10;
  localparam logic [7:0] REG_RX_DATA   = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_FIELDBUS  = 8'h1C;

  // Line configuration fields.
  localparam int LC_BAUD_LSB   = 0;
  localparam int LC_BAUD_W     = 16;
  localparam int LC_EIGHT_BIT  = 16;
  localparam int LC_PAR_LSB    = 17;
  localparam int LC_TWO_STOP   = 19;

  // Port configuration fields.
  localparam int PC_PROTOCOL_SELECT_LSB  = 0;
  localparam int PC_AUTO       = 4;
  localparam int PC_HW_HS      = 5;
  localparam int PC_BIN_OP     = 6;
  localparam int PC_IF485      = 7;
  localparam int PC_CARD       = 8;

  localparam logic [15:0] BAUD_MIN     = 16'd300;
  localparam logic [15:0] BAUD_MAX     = 16'd38400;
  localparam logic [15:0] BAUD_DEFAULT = 16'd9600;
  localparam logic [4:0]  TOUT_DEFAULT = 5'd5;
  localparam logic [4:0]  TOUT_MAX     = 5'd30;
  localparam logic [5:0]  NODE_MAX     = 6'd63;

  localparam int CLK_HZ        = 40000000;
  localparam int MINUTE_S      = 60;
  localparam logic [31:0] CYCLES_PER_MIN = 32'(64'(CLK_HZ) * 64'(MINUTE_S));

  localparam logic [7:0] CHAR_XON  = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;

  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} spl_parity_e;

  typedef enum logic [3:0] {
    PROTOCOL_SELECT_ASCII, PROTOCOL_SELECT_MODBUS_RTU, PROTOCOL_SELECT_PEER_A, PROTOCOL_SELECT_PEER_B,
    PROTOCOL_SELECT_PEER8_A, PROTOCOL_SELECT_PEER8_B, PROTOCOL_SELECT_MODEM_A, PROTOCOL_SELECT_MODEM_B, PROTOCOL_SELECT_FIELDBUS
  } spl_protocol_select_e;

  typedef struct packed {
    logic        twoStop;
    spl_parity_e parity;
    logic        eightBit;
    logic [15:0] baud;
  } spl_line_s;

  localparam spl_line_s LINE_RESET = '{twoStop: 1'b0, parity: PAR_NONE, eightBit: 1'b1, baud: BAUD_DEFAULT};

  function automatic logic [15:0] spl_bit_cycles(input logic [15:0] baud);
    logic [31:0] q;
    q = 32'(CLK_HZ) / {16'h0000, baud};
    return q[15:0];
  endfunction

endpackage

// file: logic/spl_port.sv
`timescale 1ns/100ps
// Operation
// - Configurable baud, data bits, parity, stop bits.
// - Idle timeout drops elevated access to lowest.
// - Timeout zero disables access drop entirely.
// - Modem option sends every second interval.
// - Modem option holds RTS deasserted.
// - Modem option ignores CTS low for flow control.
// - Automatic messages only when enabled.
// - XON/XOFF flow control honoured except in fieldbus mode with a card present.
// - Optional RTS/CTS hardware flow control.
// - Binary operate messages only when enabled.
// - Run only the selected protocol.
// - Fieldbus selection routes via the card when one is present.
// - Card present hides line and timeout settings.
// - Rear port is EIA-232 or EIA-485, not both.
module spl_port #(
  parameter logic [31:0] CYCLES_PER_MIN = spl_pkg::CYCLES_PER_MIN
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Protocol engine side.
  input  wire logic        intervalTick,
  output logic             msgSlot,
  input  wire logic        autoMsgReq,
  output logic             autoMsgAllow,
  input  wire logic        binOpReq,
  output logic             binOpAccept,
  output logic             binOpReject,
  output logic [8:0]       protoActive,
  // Fieldbus card.
  input  wire logic        cardPresent,
  input  wire logic        cardTxReady,
  output logic             cardTxValid,
  output logic [7:0]       cardTxData,
  input  wire logic        cardRxValid,
  input  wire logic [7:0]  cardRxData,
  // Serial pins.
  input  wire logic        rxd232,
  output logic             txd232,
  input  wire logic        cts232,
  output logic             rts232,
  input  wire logic        rx485,
  output logic             tx485,
  output logic             de485
);

  ////////////////////////////////////////////////////////////////////////////////
  spl_pkg::spl_line_s lineCfg;
  spl_pkg::spl_protocol_select_e protoPick;
  logic        autoEnable;
  logic        hwHandshake;
  logic        binOpEnable;
  logic        if485;
  logic [4:0]  timeoutMin;
  logic        accessHigh;
  logic        accessSetReq;
  logic [7:0]  txHold;
  logic        txHoldValid;
  logic [7:0]  rxHold;
  logic        rxHoldValid;
  logic        rxErrSticky;
  logic        xoffActive;
  logic [4:0]  minLeft;
  logic [31:0] cycLeft;
  logic        halfSlot;
  logic        modemMode;
  logic        fieldbusMode;
  logic        holdOff;
  logic        txReady;
  logic        txLine;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxError;
  logic        rxLine;
  logic        anyRx;
  logic        awSeen;
  logic        wSeen;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;
  logic        rdRx;

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data latched in any order, one write in flight.
  assign s_axi_awready = ~awSeen & ~s_axi_bvalid;
  assign s_axi_wready  = ~wSeen & ~s_axi_bvalid;
  assign doWrite       = awSeen & wSeen & ~s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awSeen <= 1'b0;
      wSeen  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSeen <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wSeen <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awSeen       <= 1'b0;
        wSeen        <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unmapped writes are accepted and answered OKAY but change nothing.
  assign s_axi_bresp = 2'b00;

  // Configuration registers.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lineCfg     <= spl_pkg::LINE_RESET;
      protoPick   <= spl_pkg::PROTOCOL_SELECT_ASCII;
      autoEnable  <= 1'b0;
      hwHandshake <= 1'b0;
      binOpEnable <= 1'b0;
      if485       <= 1'b0;
      timeoutMin  <= spl_pkg::TOUT_DEFAULT;
    end else if (doWrite && !cardPresent) begin
      // While the card is present all settings are frozen; line and timeout settings read back as zero.
      if (awAddr == spl_pkg::REG_LINE_CFG) begin
        if (wStrb[1] && wStrb[0] && wData[15:0] >= spl_pkg::BAUD_MIN && wData[15:0] <= spl_pkg::BAUD_MAX) begin
          lineCfg.baud <= wData[15:0];
        end
        if (wStrb[2]) begin
          lineCfg.eightBit <= wData[spl_pkg::LC_EIGHT_BIT];
          if (wData[spl_pkg::LC_PAR_LSB +: 2] != 2'b11) begin
            lineCfg.parity <= spl_pkg::spl_parity_e'(wData[spl_pkg::LC_PAR_LSB +: 2]);
          end
          lineCfg.twoStop <= wData[spl_pkg::LC_TWO_STOP];
        end
      end
      if (awAddr == spl_pkg::REG_PORT_CFG) begin
        if (wStrb[0]) begin
          if (wData[spl_pkg::PC_PROTOCOL_SELECT_LSB +: 4] <= 4'(spl_pkg::PROTOCOL_SELECT_FIELDBUS)) begin
            protoPick <= spl_pkg::spl_protocol_select_e'(wData[spl_pkg::PC_PROTOCOL_SELECT_LSB +: 4]);
          end
          autoEnable  <= wData[spl_pkg::PC_AUTO];
          hwHandshake <= wData[spl_pkg::PC_HW_HS];
          binOpEnable <= wData[spl_pkg::PC_BIN_OP];
          if485       <= wData[spl_pkg::PC_IF485];
        end
      end
      if (awAddr == spl_pkg::REG_TIMEOUT && wStrb[0] && wData[4:0] <= spl_pkg::TOUT_MAX) begin
        timeoutMin <= wData[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;
  assign rdRx          = s_axi_arvalid & s_axi_arready & (s_axi_araddr == spl_pkg::REG_RX_DATA);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        spl_pkg::REG_LINE_CFG: s_axi_rdata <= cardPresent ? 32'h0 : {12'h000, lineCfg};
        spl_pkg::REG_PORT_CFG: s_axi_rdata <= {23'h0, cardPresent, if485, binOpEnable, hwHandshake,
                                                autoEnable, protoPick};
        spl_pkg::REG_TIMEOUT:  s_axi_rdata <= cardPresent ? 32'h0 : {27'h0, timeoutMin};
        spl_pkg::REG_ACCESS:   s_axi_rdata <= {26'h0, minLeft, accessHigh};
        spl_pkg::REG_RX_DATA:  s_axi_rdata <= {23'h0, rxHoldValid, rxHold};
        spl_pkg::REG_STATUS:   s_axi_rdata <= {26'h0, cts232, rxErrSticky, xoffActive, txHoldValid,
                                                txReady, rxHoldValid};
        default:               s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.
  assign modemMode    = (protoPick == spl_pkg::PROTOCOL_SELECT_MODEM_A) | (protoPick == spl_pkg::PROTOCOL_SELECT_MODEM_B);
  assign fieldbusMode = (protoPick == spl_pkg::PROTOCOL_SELECT_FIELDBUS) & cardPresent;

  always_comb begin
    protoActive = 9'h000;
    protoActive[protoPick] = 1'b1;
  end

  // Under the modem option CTS low means a noisy channel, not a flow stop.
  assign holdOff = xoffActive | (hwHandshake & ~modemMode & ~cts232);

  // RTS is held low under the modem option, else our ready-to-receive under handshaking, otherwise idle asserted.
  assign rts232 = modemMode ? 1'b0 : (hwHandshake ? ~rxHoldValid : 1'b1);

  assign autoMsgAllow = autoMsgReq & autoEnable;
  assign binOpAccept  = binOpReq & binOpEnable;
  assign binOpReject  = binOpReq & ~binOpEnable;

  ////////////////////////////////////////////////////////////////////////////////
  // Message slots: every interval, or every second one under the modem option.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halfSlot <= 1'b0;
      msgSlot  <= 1'b0;
    end else begin
      msgSlot <= 1'b0;
      if (intervalTick) begin
        halfSlot <= ~halfSlot;
        msgSlot  <= ~modemMode | halfSlot;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit holding register, serial line or fieldbus card.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txHold      <= 8'h00;
      txHoldValid <= 1'b0;
    end else begin
      if (doWrite && awAddr == spl_pkg::REG_TX_DATA && wStrb[0] && !txHoldValid) begin
        txHold      <= wData[7:0];
        txHoldValid <= 1'b1;
      end else if (txHoldValid && (fieldbusMode ? cardTxReady : txReady)) begin
        txHoldValid <= 1'b0;
      end
    end
  end

  assign cardTxValid = txHoldValid & fieldbusMode;
  assign cardTxData  = txHold;

  spl_tx u_tx (
    .core_clk (core_clk),
    .srst     (srst),
    .lineCfg  (lineCfg),
    .holdOff  (holdOff),
    .txValid  (txHoldValid & ~fieldbusMode),
    .txData   (txHold),
    .txReady  (txReady),
    .txLine   (txLine)
  );

  // The unselected interface idles high; de485 stays high except while an EIA-485 frame is busy or held off.
  assign txd232 = if485 ? 1'b1 : txLine;
  assign tx485  = if485 ? txLine : 1'b1;
  assign de485  = ~(if485 & ~txReady);
  assign rxLine = if485 ? rx485 : rxd232;

  spl_rx u_rx (
    .core_clk (core_clk),
    .srst     (srst),
    .lineCfg  (lineCfg),
    .rxLine   (rxLine),
    .rxValid  (rxValid),
    .rxData   (rxData),
    .rxError  (rxError)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive holding, flow characters and error flag; a new event wins over a read.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxHold      <= 8'h00;
      rxHoldValid <= 1'b0;
      xoffActive  <= 1'b0;
      rxErrSticky <= 1'b0;
    end else begin
      if (rdRx) begin
        rxHoldValid <= 1'b0;
        rxErrSticky <= 1'b0;
      end
      if (rxValid && !fieldbusMode) begin
        if (rxError) begin
          rxErrSticky <= 1'b1;
        end else if (rxData == spl_pkg::CHAR_XOFF) begin
          xoffActive <= 1'b1;
        end else if (rxData == spl_pkg::CHAR_XON) begin
          xoffActive <= 1'b0;
        end else begin
          rxHold      <= rxData;
          rxHoldValid <= 1'b1;
        end
      end else if (cardRxValid && fieldbusMode) begin
        rxHold      <= cardRxData;
        rxHoldValid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access level and inactivity timeout.
  assign anyRx        = (rxValid & ~fieldbusMode) | (cardRxValid & fieldbusMode);
  assign accessSetReq = doWrite & (awAddr == spl_pkg::REG_ACCESS) & wStrb[0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      accessHigh <= 1'b0;
      minLeft    <= 5'd0;
      cycLeft    <= 32'h0000_0000;
    end else if (accessSetReq) begin
      accessHigh <= wData[0];
      minLeft    <= timeoutMin;
      cycLeft    <= CYCLES_PER_MIN;
    end else if (accessHigh && anyRx) begin
      minLeft <= timeoutMin;
      cycLeft <= CYCLES_PER_MIN;
    end else if (accessHigh && timeoutMin != 5'd0) begin
      if (cycLeft > 32'h0000_0001) begin
        cycLeft <= cycLeft - 32'h0000_0001;
      end else if (minLeft > 5'd1) begin
        minLeft <= minLeft - 5'd1;
        cycLeft <= CYCLES_PER_MIN;
      end else begin
        accessHigh <= 1'b0;
        minLeft    <= 5'd0;
      end
    end
  end

endmodule

// file: logic/spl_rx.sv
`timescale 1ns/100ps
module spl_rx (
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               srst,
  // Framing.
  input  wire spl_pkg::spl_line_s lineCfg,
  // Line.
  input  wire logic               rxLine,
  // Character out.
  output logic                    rxValid,
  output logic [7:0]              rxData,
  output logic                    rxError
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} spl_rxst_e;
  spl_rxst_e   state;
  logic [15:0] bitCnt;
  logic [3:0]  bitIdx;
  logic [8:0]  shiftReg;
  logic [3:0]  nBits;

  always_comb begin
    nBits = 4'(4'd7 + {3'b000, lineCfg.eightBit} + {3'b000, lineCfg.parity != spl_pkg::PAR_NONE});
  end

  // Only the first stop bit is checked; a second stop reads as idle line.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state    <= RX_IDLE;
      bitCnt   <= 16'h0000;
      bitIdx   <= 4'h0;
      shiftReg <= 9'h000;
      rxValid  <= 1'b0;
      rxData   <= 8'h00;
      rxError  <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      case (state)
        RX_IDLE: begin
          if (!rxLine) begin
            state  <= RX_START;
            bitCnt <= spl_pkg::spl_bit_cycles(lineCfg.baud) >> 1;
          end
        end
        RX_START: begin
          if (bitCnt > 16'h0001) begin
            bitCnt <= bitCnt - 16'h0001;
          end else begin
            state  <= rxLine ? RX_IDLE : RX_BITS;
            bitCnt <= spl_pkg::spl_bit_cycles(lineCfg.baud);
            bitIdx <= 4'h0;
            shiftReg <= 9'h000;
          end
        end
        RX_BITS: begin
          if (bitCnt > 16'h0001) begin
            bitCnt <= bitCnt - 16'h0001;
          end else begin
            bitCnt <= spl_pkg::spl_bit_cycles(lineCfg.baud);
            if (bitIdx == nBits) begin
              state   <= RX_IDLE;
              rxValid <= 1'b1;
              rxData  <= lineCfg.eightBit ? shiftReg[7:0] : {1'b0, shiftReg[6:0]};
              rxError <= ~rxLine
                         | ((lineCfg.parity == spl_pkg::PAR_EVEN) & (^shiftReg))
                         | ((lineCfg.parity == spl_pkg::PAR_ODD) & ~(^shiftReg));
            end else begin
              shiftReg[bitIdx] <= rxLine;
              bitIdx           <= bitIdx + 4'h1;
            end
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

endmodule

// file: logic/spl_tx.sv
`timescale 1ns/100ps
module spl_tx (
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Framing.
  input  wire spl_pkg::spl_line_s lineCfg,
  input  wire logic              holdOff,
  // Character in.
  input  wire logic              txValid,
  input  wire logic [7:0]        txData,
  output logic                   txReady,
  // Line.
  output logic                   txLine
);

  logic [15:0] bitCnt;
  logic [3:0]  bitIdx;
  logic [11:0] shiftReg;
  logic [3:0]  frameLen;
  logic        busy;

  function automatic logic parityBit(input logic [7:0] d, input logic eight, input spl_pkg::spl_parity_e p);
    logic x;
    x = eight ? ^d : ^d[6:0];
    return (p == spl_pkg::PAR_ODD) ? ~x : x;
  endfunction

  // A pause only takes effect between characters, so a started frame always ends cleanly.
  assign txReady = ~busy & ~holdOff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy     <= 1'b0;
      txLine   <= 1'b1;
      bitCnt   <= 16'h0000;
      bitIdx   <= 4'h0;
      shiftReg <= 12'hFFF;
      frameLen <= 4'h0;
    end else if (!busy) begin
      txLine <= 1'b1;
      if (txValid && txReady) begin
        busy   <= 1'b1;
        bitIdx <= 4'h0;
        bitCnt <= spl_pkg::spl_bit_cycles(lineCfg.baud);
        txLine <= 1'b0;
        // Frame: data bits, optional parity, then stop bits as ones.
        if (lineCfg.parity == spl_pkg::PAR_NONE) begin
          shiftReg <= lineCfg.eightBit ? {4'hF, txData} : {5'h1F, txData[6:0]};
        end else if (lineCfg.eightBit) begin
          shiftReg <= {3'h7, parityBit(txData, 1'b1, lineCfg.parity), txData};
        end else begin
          shiftReg <= {4'hF, parityBit(txData, 1'b0, lineCfg.parity), txData[6:0]};
        end
        frameLen <= 4'(4'd7 + {3'b000, lineCfg.eightBit} + {3'b000, lineCfg.parity != spl_pkg::PAR_NONE}
                    + {3'b000, lineCfg.twoStop} + 4'd1);
      end
    end else if (bitCnt > 16'h0001) begin
      bitCnt <= bitCnt - 16'h0001;
    end else begin
      bitCnt <= spl_pkg::spl_bit_cycles(lineCfg.baud);
      if (bitIdx == frameLen) begin
        busy   <= 1'b0;
        txLine <= 1'b1;
      end else begin
        txLine   <= shiftReg[0];
        shiftReg <= {1'b1, shiftReg[11:1]};
        bitIdx   <= bitIdx + 4'h1;
      end
    end
  end

endmodule

// file: test/spl_peer_model.sv
`timescale 1ns/100ps
module spl_peer_model #(
  parameter int BIT_CYC = 40000000 / 38400
) (
  // Clock.
  input  wire logic core_clk,
  // Serial pins.
  input  wire logic rts232,
  output logic      rxd232,
  output logic      cts232
);
  logic eightChan;
  initial begin
    rxd232 = 1'b1;
    cts232 = 1'b1; // A clean channel keeps clear to send.
  end
  // The variant in use follows the device's request to send.
  always @(posedge core_clk) begin
    eightChan <= rts232;
  end
  // Framing matches the port: 8 data, no parity, 1 stop.
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd232 <= frame[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
  task automatic setCts(input logic v);
    cts232 <= v;
  endtask
endmodule

// file: test/spl_port_assertions.sv
`timescale 1ns/100ps
module spl_port_assertions #(
  parameter logic [31:0] CYCLES_PER_MIN = 32'h0000_0064
) (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        srst,
  // Engine side.
  input wire logic        intervalTick,
  input wire logic        msgSlot,
  input wire logic        autoMsgReq,
  input wire logic        autoMsgAllow,
  input wire logic        binOpReq,
  input wire logic        binOpAccept,
  input wire logic        binOpReject,
  input wire logic [8:0]  protoActive,
  input wire logic        cardTxValid,
  input wire logic        rts232,
  // Read channel.
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  wire logic modem;
  assign modem = protoActive[6] | protoActive[7];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  slot_after_tick_a: assert property (msgSlot |-> $past(intervalTick))
    else $error("Slot without a tick.");
  slot_each_tick_a: assert property (intervalTick && !modem |=> msgSlot)
    else $error("Tick without a slot.");
  auto_gate_a: assert property (autoMsgAllow |-> autoMsgReq)
    else $error("Automatic message without request.");
  binop_gate_a: assert property (binOpAccept |-> binOpReq && !binOpReject)
    else $error("Bad operate answer.");
  binop_answer_a: assert property (binOpReq |-> binOpAccept || binOpReject)
    else $error("Operate request unanswered.");
  protocol_select_onehot_a: assert property ($onehot(protoActive))
    else $error("Protocol select not one-hot.");
  modem_rts_a: assert property (modem |-> !rts232)
    else $error("Request to send high in modem mode.");
  card_route_a: assert property (cardTxValid |-> protoActive[8])
    else $error("Card traffic outside fieldbus mode.");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped.");
endmodule
////////////////////////////////////////
bind spl_port spl_port_assertions #(.CYCLES_PER_MIN(CYCLES_PER_MIN)) u_spl_chk (
  .core_clk(core_clk), .srst(srst), .intervalTick(intervalTick), .msgSlot(msgSlot),
  .autoMsgReq(autoMsgReq), .autoMsgAllow(autoMsgAllow), .binOpReq(binOpReq),
  .binOpAccept(binOpAccept), .binOpReject(binOpReject), .protoActive(protoActive),
  .cardTxValid(cardTxValid), .rts232(rts232), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic core_clk, srst, sAwvalid, sWvalid, sBready, sArvalid, sRready;
  logic sAwready, sWready, sBvalid, sArready, sRvalid, rxd232, txd232, cts232, rts232;
  logic intervalTick, autoMsgReq, binOpReq, msgSlot, autoMsgAllow, binOpAccept, binOpReject, cardPresent, cardRxValid;
  logic [7:0]  sAwaddr, sAraddr;
  logic [31:0] sWdata, sRdata, rv;
  logic [8:0]  protoActive;
  int err_total = 0;
  int check_count = 0;
  int slotCnt = 0;
  int lowCnt = 0;
  int cyc = 0;
  spl_port #(.CYCLES_PER_MIN(32'h0000_0064)) DUT (
    .core_clk(core_clk), .srst(srst), .s_axi_awaddr(sAwaddr), .s_axi_awvalid(sAwvalid),
    .s_axi_awready(sAwready), .s_axi_wdata(sWdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(sWvalid),
    .s_axi_wready(sWready), .s_axi_bresp(), .s_axi_bvalid(sBvalid), .s_axi_bready(sBready),
    .s_axi_araddr(sAraddr), .s_axi_arvalid(sArvalid), .s_axi_arready(sArready),
    .s_axi_rdata(sRdata), .s_axi_rresp(), .s_axi_rvalid(sRvalid), .s_axi_rready(sRready),
    .intervalTick(intervalTick), .msgSlot(msgSlot), .autoMsgReq(autoMsgReq),
    .autoMsgAllow(autoMsgAllow), .binOpReq(binOpReq), .binOpAccept(binOpAccept),
    .binOpReject(binOpReject), .protoActive(protoActive), .cardPresent(cardPresent),
    .cardTxReady(1'b1), .cardTxValid(), .cardTxData(), .cardRxValid(cardRxValid),
    .cardRxData(8'h00), .rxd232(rxd232), .txd232(txd232), .cts232(cts232),
    .rts232(rts232), .rx485(1'b1), .tx485(), .de485());
  spl_peer_model peer (.core_clk(core_clk), .rts232(rts232), .rxd232(rxd232), .cts232(cts232));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (msgSlot) slotCnt++;
    if (!txd232) lowCnt++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Ready is sampled at the falling edge so the rising edge that follows is the handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    sAwaddr <= a;
    sWdata <= d;
    sAwvalid <= 1'b1;
    sWvalid <= 1'b1;
    sBready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    while (!(aw && w)) begin
      @(negedge core_clk);
      aw = aw | (sAwvalid & sAwready);
      w = w | (sWvalid & sWready);
      @(posedge core_clk);
      if (aw) sAwvalid <= 1'b0;
      if (w) sWvalid <= 1'b0;
    end
    while (!b) begin
      @(negedge core_clk);
      b = sBvalid;
      @(posedge core_clk);
    end
    sBready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic t;
    sAraddr <= a;
    sArvalid <= 1'b1;
    sRready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge core_clk);
      t = sArready;
      @(posedge core_clk);
    end
    sArvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge core_clk);
      t = sRvalid;
      d = sRdata;
      @(posedge core_clk);
    end
    sRready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {srst, sAwvalid, sWvalid, sBready, sArvalid, sRready} = 6'h3F & 6'h20;
    {sAwaddr, sAraddr, sWdata} = 48'h0;
    {intervalTick, autoMsgReq, binOpReq, cardPresent, cardRxValid} = 5'h0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(8'h00, rv);
    chk(rv, 32'h0001_2580);
    wr(8'h00, 32'h0001_012B);
    rd(8'h00, rv);
    chk(rv, 32'h0001_2580);
    wr(8'h00, 32'h000D_9600);
    rd(8'h00, rv);
    chk(rv, 32'h000D_9600);
    wr(8'h00, 32'h0001_9600);
    rd(8'h20, rv);
    chk(rv, 32'h0);
    rd(8'h04, rv);
    chk(rv, 32'h0);
    $display("Framing test done.");
    wr(8'h08, 32'h1F);
    rd(8'h08, rv);
    chk(rv, 32'h5);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h1);
    repeat (80) @(posedge core_clk);
    rd(8'h0C, rv);
    chk(rv & 32'h1, 32'h1);
    repeat (40) @(posedge core_clk);
    rd(8'h0C, rv);
    chk(rv & 32'h1, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h1);
    repeat (300) @(posedge core_clk);
    rd(8'h0C, rv);
    chk(rv & 32'h1, 32'h1);
    $display("Access timeout test done.");
    autoMsgReq <= 1'b1;
    binOpReq <= 1'b1;
    @(posedge core_clk);
    chk(32'({autoMsgAllow, binOpAccept, binOpReject}), 32'h1);
    wr(8'h04, 32'h50);
    chk(32'({autoMsgAllow, binOpAccept, binOpReject}), 32'h6);
    autoMsgReq <= 1'b0;
    binOpReq <= 1'b0;
    for (int p = 0; p < 9; p++) begin
      wr(8'h04, 32'(p));
      slotCnt = 0;
      repeat (4) begin
        intervalTick <= 1'b1;
        @(posedge core_clk);
        intervalTick <= 1'b0;
        repeat (3) @(posedge core_clk);
      end
      chk(32'(protoActive), 32'h1 << p);
      chk(slotCnt, (p == 6 || p == 7) ? 2 : 4);
      if (p == 6 || p == 7) chk(32'(rts232), 32'h0);
    end
    peer.setCts(1'b0);
    wr(8'h04, 32'h20);
    rd(8'h18, rv);
    chk(rv & 32'h22, 32'h0);
    wr(8'h04, 32'h26);
    rd(8'h18, rv);
    chk(rv & 32'h22, 32'h2);
    peer.setCts(1'b1);
    wr(8'h04, 32'h0);
    $display("Protocol test done.");
    peer.sendByte(spl_pkg::CHAR_XOFF);
    repeat (600) @(posedge core_clk);
    rd(8'h18, rv);
    chk(rv & 32'h8, 32'h8);
    wr(8'h10, 32'h55);
    lowCnt = 0;
    repeat (3000) @(posedge core_clk);
    chk(lowCnt, 0);
    peer.sendByte(spl_pkg::CHAR_XON);
    lowCnt = 0;
    repeat (2000) @(posedge core_clk);
    chk(32'(lowCnt > 0), 32'h1);
    wr(8'h04, 32'h8);
    {cardPresent, cardRxValid} <= 2'h3;
    rd(8'h00, rv);
    chk(rv, 32'h0);
    rd(8'h14, rv);
    chk(rv, 32'h100);
    $display("Flow control test done.");
    summarize();
  end
endmodule
